// ---- rtl/gtp_pkg.sv ----
package gtp_pkg;

  // register byte offsets on the wishbone slave
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_INTERVAL = 8'h04;
  localparam logic [7:0] A_START_DATE = 8'h08;
  localparam logic [7:0] A_START_TIME = 8'h0c;
  localparam logic [7:0] A_NOW_DATE = 8'h10;
  localparam logic [7:0] A_NOW_TIME = 8'h14;
  localparam logic [7:0] A_OFFSET = 8'h18;
  localparam logic [7:0] A_LEAP = 8'h1c;
  localparam logic [7:0] A_TIMECODE = 8'h20;
  localparam logic [7:0] A_TAG_CLEAR = 8'h24;
  localparam logic [7:0] A_OVF_TOTAL = 8'h28;
  localparam logic [7:0] A_POINTS = 8'h2c;
  localparam logic [7:0] A_DATA1 = 8'h30;
  localparam logic [7:0] A_DATA2 = 8'h34;
  localparam logic [7:0] A_DATA3 = 8'h38;
  localparam logic [7:0] A_OVF_CHAN = 8'h3c;
  localparam logic [7:0] A_IRQ_STAT = 8'h40;
  localparam logic [7:0] A_IRQ_MASK = 8'h44;

  // control register fields
  localparam int B_TRAIN = 0;
  localparam int B_PPOL = 1;
  localparam int B_SPOL = 2;
  localparam int B_ARM = 3;
  localparam int B_TPOL = 4;
  localparam int B_KEEPLAST = 7;
  localparam logic [7:0] RST_CTRL = 8'h00;

  // interrupt status bits
  localparam int I_PULSE = 0;
  localparam int I_TC = 1;
  localparam int I_TAG = 2;
  localparam int I_OVF = 5;
  localparam int NIRQ = 6;

  // capture channels and their buffers
  localparam int NCH = 3;
  localparam int DEPTH = 8;
  localparam logic [3:0] DEPTH_CNT = 4'h8;

  // timing
  localparam int CLK_NS = 50;
  localparam int TC_EARLY_MS = 980;
  localparam int TC_LATE_MS = 20;
  localparam int PULSE_NS = 1000;
  localparam logic [7:0] PULSE_CYC = 8'((PULSE_NS + CLK_NS - 1) / CLK_NS);
  localparam int SEC_PER_DAY = 86400;
  localparam logic [16:0] LAST_SEC = 17'h1517f;
  localparam int SUBW = 25;

  // reset values of date and settings
  localparam logic [15:0] RST_YEAR = 16'h07d0;
  localparam logic [7:0] RST_LEAP = 8'h00;
  localparam logic [31:0] RST_INTERVAL = 32'h0000_0001;

  typedef logic [SUBW-1:0] gtp_sub_t;
  typedef logic [2:0] gtp_ptr_t;

  typedef struct packed {
    logic [15:0] year;
    logic [7:0] month;
    logic [7:0] day;
  } gtp_date_s;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } gtp_wb_req_s;

  typedef enum logic [1:0] {
    TC_IDLE = 2'b00,
    TC_WAIT = 2'b01,
    TC_DONE = 2'b10
  } gtp_tc_e;

  typedef enum logic [1:0] {
    PG_IDLE = 2'b00,
    PG_ARMED = 2'b01,
    PG_TRAIN = 2'b10
  } gtp_pg_e;

endpackage

// ---- rtl/gtp_pin_sync.sv ----
`timescale 1ns/1ps
module gtp_pin_sync (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // raw pins and qualified edges
  input wire logic [gtp_pkg::NCH-1:0] pin,
  output logic [gtp_pkg::NCH-1:0] rise,
  output logic [gtp_pkg::NCH-1:0] fall
);

  typedef struct packed {
    logic [gtp_pkg::NCH-1:0] ff1;
    logic [gtp_pkg::NCH-1:0] ff2;
    logic [gtp_pkg::NCH-1:0] ff3;
    logic [gtp_pkg::NCH-1:0] level;
    logic [gtp_pkg::NCH-1:0] rise;
    logic [gtp_pkg::NCH-1:0] fall;
  } gtp_sync_s;

  gtp_sync_s s;
  gtp_sync_s next_s;

  // a change counts only once the second and third stages agree
  always_comb begin
    next_s = s;
    next_s.ff1 = pin;
    next_s.ff2 = s.ff1;
    next_s.ff3 = s.ff2;
    for (int i = 0; i < gtp_pkg::NCH; i++) begin
      if (s.ff2[i] == s.ff3[i]) begin
        next_s.level[i] = s.ff3[i];
      end
    end
    next_s.rise = next_s.level & ~s.level;
    next_s.fall = ~next_s.level & s.level;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign rise = s.rise;
  assign fall = s.fall;

endmodule

// ---- rtl/gtp_tag_chan.sv ----
`timescale 1ns/1ps
module gtp_tag_chan (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // capture side
  input wire logic capture,
  input wire logic [31:0] stamp,
  input wire logic keep_last,
  // software side
  input wire logic clear,
  input wire logic pop,
  output logic [31:0] head,
  output logic [3:0] count,
  output logic [7:0] ovf_cnt,
  output logic stored,
  output logic lost
);

  typedef struct packed {
    logic [gtp_pkg::DEPTH-1:0][31:0] mem;
    gtp_pkg::gtp_ptr_t rd;
    gtp_pkg::gtp_ptr_t wr;
    logic [3:0] count;
    logic [7:0] ovf;
    logic stored;
    logic lost;
  } gtp_chan_s;

  gtp_chan_s s;
  gtp_chan_s next_s;

  // pop before push, so a read and an edge in one cycle both land
  always_comb begin
    next_s = s;
    next_s.stored = 1'b0;
    next_s.lost = 1'b0;
    if (clear) begin
      next_s.rd = '0;
      next_s.wr = '0;
      next_s.count = 4'h0;
      next_s.ovf = 8'h00;
    end else begin
      if (pop && s.count != 4'h0) begin
        next_s.rd = s.rd + 3'h1;
        next_s.count = s.count - 4'h1;
      end
      if (capture) begin
        if (next_s.count == gtp_pkg::DEPTH_CNT) begin
          next_s.lost = 1'b1;
          if (s.ovf != 8'hff) begin
            next_s.ovf = s.ovf + 8'h01;
          end
          if (keep_last) begin
            next_s.mem[next_s.wr] = stamp;
            next_s.wr = next_s.wr + 3'h1;
            next_s.rd = next_s.rd + 3'h1;
          end
        end else begin
          next_s.mem[next_s.wr] = stamp;
          next_s.wr = next_s.wr + 3'h1;
          next_s.count = next_s.count + 4'h1;
          next_s.stored = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign head = (s.count == 4'h0) ? 32'h0000_0000 : s.mem[s.rd];
  assign count = s.count;
  assign ovf_cnt = s.ovf;
  assign stored = s.stored;
  assign lost = s.lost;

endmodule

// ---- rtl/gtp_time_io.sv ----
`timescale 1ns/1ps
// Function
// - timecode ready 980 to 20 ms before edge
// - local offset stored, applied, readable
// - second mark on-time edge polarity selectable
// - leap second total readable in seconds
// - train interval in seconds, readable
// - train mode: single pulse or repeating train
// - pulse on-time edge polarity selectable
// - start date: year, month, day
// - start time hms; fire when clock matches
// - three edge time-tag channels
// - per-channel capture edge polarity
// - clear all buffers, or one channel
// - read returns channel buffer stamps
module gtp_time_io #(
  parameter int unsigned CYC_PER_SEC = 20000000
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // timing pins
  input wire logic [gtp_pkg::NCH-1:0] tag_channel,
  output logic second_mark,
  output logic pulse_out,
  // interrupt
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // timing derived from the clock rate

  // earliest point rounds up, latest rounds down, both inside the window
  localparam gtp_pkg::gtp_sub_t TC_OPEN = gtp_pkg::gtp_sub_t'(longint'(CYC_PER_SEC)
    - (longint'(gtp_pkg::TC_EARLY_MS) * longint'(CYC_PER_SEC)) / 1000);
  localparam gtp_pkg::gtp_sub_t TC_CLOSE = gtp_pkg::gtp_sub_t'(longint'(CYC_PER_SEC)
    - (longint'(gtp_pkg::TC_LATE_MS) * longint'(CYC_PER_SEC) + 999) / 1000);
  localparam gtp_pkg::gtp_sub_t SUB_LAST = gtp_pkg::gtp_sub_t'(CYC_PER_SEC - 1);
  localparam gtp_pkg::gtp_sub_t SUB_HALF = gtp_pkg::gtp_sub_t'(CYC_PER_SEC / 2);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // byte-lane merge of a wishbone write
  function automatic logic [31:0] wmerge(logic [31:0] o, logic [31:0] d, logic [3:0] sel);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = d[8*b +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [16:0] hms_to_sec(logic [23:0] hms);
    return 17'(int'(hms[23:16]) * 3600 + int'(hms[15:8]) * 60 + int'(hms[7:0]));
  endfunction

  // offset is signed hours in [15:8], minutes in [7:0] carrying the hour sign
  function automatic logic [16:0] to_local(logic [16:0] tod, logic [15:0] off);
    int h;
    int m;
    int t;
    h = int'($signed(off[15:8]));
    m = int'(off[7:0]);
    t = int'(tod) + h * 3600 + ((h < 0) ? -m : m) * 60;
    if (t < 0) begin
      t = t + gtp_pkg::SEC_PER_DAY;
    end else if (t >= gtp_pkg::SEC_PER_DAY) begin
      t = t - gtp_pkg::SEC_PER_DAY;
    end
    return 17'(t);
  endfunction

  function automatic logic [7:0] month_days(gtp_pkg::gtp_date_s d);
    logic [7:0] r;
    case (d.month)
      8'h02: r = (d.year[1:0] == 2'b00) ? 8'h1d : 8'h1c;
      8'h04, 8'h06, 8'h09, 8'h0b: r = 8'h1e;
      default: r = 8'h1f;
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic wb_ack;
    logic [31:0] wb_dat;
    logic [7:0] ctrl;
    logic [31:0] interval;
    gtp_pkg::gtp_date_s start_date;
    logic [23:0] start_hms;
    gtp_pkg::gtp_date_s now_date;
    logic [16:0] tod;
    gtp_pkg::gtp_sub_t sub;
    logic [15:0] offset;
    logic [7:0] leap;
    gtp_pkg::gtp_tc_e tc_state;
    logic [16:0] tc_tod;
    gtp_pkg::gtp_pg_e pg_state;
    logic [31:0] pg_cnt;
    logic [7:0] pulse_cnt;
    logic pulse_out;
    logic second_mark;
    logic [gtp_pkg::NIRQ-1:0] irq_stat;
    logic [gtp_pkg::NIRQ-1:0] irq_mask;
    logic irq;
    logic [15:0] ovf_total;
  } gtp_top_s;

  gtp_top_s s;
  gtp_top_s next_s;
  gtp_pkg::gtp_wb_req_s req;
  logic [gtp_pkg::NCH-1:0] rise;
  logic [gtp_pkg::NCH-1:0] fall;
  logic [gtp_pkg::NCH-1:0] capture;
  logic [gtp_pkg::NCH-1:0] clr;
  logic [gtp_pkg::NCH-1:0] pop;
  logic [gtp_pkg::NCH-1:0] stored;
  logic [gtp_pkg::NCH-1:0] lost;
  logic [gtp_pkg::NCH-1:0][31:0] head;
  logic [gtp_pkg::NCH-1:0][3:0] count;
  logic [gtp_pkg::NCH-1:0][7:0] ovf_cnt;
  logic take;
  logic [31:0] stamp;

  assign req = '{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i};
  // one access per request; ack drops the cycle after it is given
  assign take = req.cyc && req.stb && !s.wb_ack;
  assign stamp = {to_local(s.tod, s.offset), s.sub[gtp_pkg::SUBW-1 -: 15]};

  ////////////////////////////////////////////////////////////////////////////
  // capture channels

  gtp_pin_sync u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .pin(tag_channel),
    .rise(rise),
    .fall(fall)
  );

  // side effects of bus access land on the ack edge
  always_comb begin
    clr = '0;
    pop = '0;
    for (int i = 0; i < gtp_pkg::NCH; i++) begin
      capture[i] = s.ctrl[gtp_pkg::B_TPOL + i] ? fall[i] : rise[i];
      pop[i] = take && !req.we && (req.adr == gtp_pkg::A_DATA1 + 8'(4 * i));
    end
    if (take && req.we && req.adr == gtp_pkg::A_TAG_CLEAR) begin
      clr = (req.dat[2:0] == 3'h0) ? 3'h7 : req.dat[2:0];
    end
  end

  for (genvar g = 0; g < gtp_pkg::NCH; g++) begin : g_chan
    gtp_tag_chan u_chan (
      .sys_clk(sys_clk),
      .rst(rst),
      .capture(capture[g]),
      .stamp(stamp),
      .keep_last(s.ctrl[gtp_pkg::B_KEEPLAST]),
      .clear(clr[g]),
      .pop(pop[g]),
      .head(head[g]),
      .count(count[g]),
      .ovf_cnt(ovf_cnt[g]),
      .stored(stored[g]),
      .lost(lost[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic tick;
    logic [31:0] rv;
    logic [31:0] wv;
    logic [gtp_pkg::NIRQ-1:0] ev;
    logic fire;
    logic [16:0] edge_tod;
    tick = 1'b0;
    rv = 32'h0000_0000;
    wv = 32'h0000_0000;
    ev = '0;
    fire = 1'b0;
    edge_tod = 17'h0;
    next_s = s;
    next_s.wb_ack = take;

    // time of day with calendar roll
    if (s.sub == SUB_LAST) begin
      next_s.sub = '0;
      tick = 1'b1;
      if (s.tod == gtp_pkg::LAST_SEC) begin
        next_s.tod = 17'h0;
        if (s.now_date.day >= month_days(s.now_date)) begin
          next_s.now_date.day = 8'h01;
          if (s.now_date.month >= 8'h0c) begin
            next_s.now_date.month = 8'h01;
            next_s.now_date.year = s.now_date.year + 16'h0001;
          end else begin
            next_s.now_date.month = s.now_date.month + 8'h01;
          end
        end else begin
          next_s.now_date.day = s.now_date.day + 8'h01;
        end
      end else begin
        next_s.tod = s.tod + 17'h1;
      end
    end else begin
      next_s.sub = s.sub + 1'b1;
    end

    // timecode for the coming edge, only inside the allowed window
    edge_tod = (s.tod == gtp_pkg::LAST_SEC) ? 17'h0 : s.tod + 17'h1;
    case (s.tc_state)
      gtp_pkg::TC_WAIT: begin
        if (s.sub >= TC_OPEN && s.sub < TC_CLOSE) begin
          next_s.tc_tod = to_local(edge_tod, s.offset);
          next_s.tc_state = gtp_pkg::TC_DONE;
          ev[gtp_pkg::I_TC] = 1'b1;
        end
      end
      gtp_pkg::TC_DONE: begin
        if (tick) begin
          next_s.tc_state = gtp_pkg::TC_IDLE; // stale once its edge has passed
        end
      end
      gtp_pkg::TC_IDLE: begin
      end
      default: begin
        next_s.tc_state = gtp_pkg::TC_IDLE;
      end
    endcase

    // pulse generator, evaluated against the time just reached
    case (s.pg_state)
      gtp_pkg::PG_ARMED: begin
        if (tick && next_s.now_date == s.start_date &&
            next_s.tod == hms_to_sec(s.start_hms)) begin
          fire = 1'b1;
          next_s.pg_cnt = s.interval;
          next_s.pg_state = s.ctrl[gtp_pkg::B_TRAIN] ? gtp_pkg::PG_TRAIN
                                                     : gtp_pkg::PG_IDLE;
        end
      end
      gtp_pkg::PG_TRAIN: begin
        if (tick) begin
          if (s.pg_cnt <= 32'h1) begin
            fire = 1'b1;
            next_s.pg_cnt = s.interval;
          end else begin
            next_s.pg_cnt = s.pg_cnt - 32'h1;
          end
        end
      end
      gtp_pkg::PG_IDLE: begin
      end
      default: begin
        next_s.pg_state = gtp_pkg::PG_IDLE;
      end
    endcase
    ev[gtp_pkg::I_PULSE] = fire;
    if (fire) begin
      next_s.pulse_cnt = gtp_pkg::PULSE_CYC;
    end else if (s.pulse_cnt != 8'h00) begin
      next_s.pulse_cnt = s.pulse_cnt - 8'h01;
    end

    // capture bookkeeping
    ev[gtp_pkg::I_TAG +: gtp_pkg::NCH] = stored;
    ev[gtp_pkg::I_OVF] = |lost;
    next_s.ovf_total = s.ovf_total + {15'h0, lost[0]} + {15'h0, lost[1]}
                       + {15'h0, lost[2]};
    if (clr == 3'h7) begin
      next_s.ovf_total = 16'h0000;
    end

    // register reads
    case (req.adr)
      gtp_pkg::A_CTRL: rv = {24'h0, s.ctrl};
      gtp_pkg::A_INTERVAL: rv = s.interval;
      gtp_pkg::A_START_DATE: rv = s.start_date;
      gtp_pkg::A_START_TIME: rv = {8'h0, s.start_hms};
      gtp_pkg::A_NOW_DATE: rv = s.now_date;
      gtp_pkg::A_NOW_TIME: rv = {15'h0, to_local(s.tod, s.offset)};
      gtp_pkg::A_OFFSET: rv = {16'h0, s.offset};
      gtp_pkg::A_LEAP: rv = {24'h0, s.leap};
      gtp_pkg::A_TIMECODE: rv = {s.tc_state == gtp_pkg::TC_DONE, 14'h0, s.tc_tod};
      gtp_pkg::A_OVF_TOTAL: rv = {16'h0, s.ovf_total};
      gtp_pkg::A_POINTS: rv = {20'h0, count[2], count[1], count[0]};
      gtp_pkg::A_DATA1: rv = head[0];
      gtp_pkg::A_DATA2: rv = head[1];
      gtp_pkg::A_DATA3: rv = head[2];
      gtp_pkg::A_OVF_CHAN: rv = {8'h0, ovf_cnt[2], ovf_cnt[1], ovf_cnt[0]};
      gtp_pkg::A_IRQ_STAT: rv = {26'h0, s.irq_stat};
      gtp_pkg::A_IRQ_MASK: rv = {26'h0, s.irq_mask};
      default: rv = 32'h0000_0000;
    endcase
    if (take && !req.we) begin
      next_s.wb_dat = rv;
      if (req.adr == gtp_pkg::A_IRQ_STAT) begin
        next_s.irq_stat = '0;
      end
    end

    // register writes; unmapped offsets are acked and ignored
    if (take && req.we) begin
      wv = wmerge(rv, req.dat, req.sel);
      case (req.adr)
        gtp_pkg::A_CTRL: begin
          next_s.ctrl = wv[7:0];
          if (!wv[gtp_pkg::B_ARM]) begin
            next_s.pg_state = gtp_pkg::PG_IDLE;
          end else if (!s.ctrl[gtp_pkg::B_ARM]) begin
            next_s.pg_state = gtp_pkg::PG_ARMED;
          end
        end
        gtp_pkg::A_INTERVAL: next_s.interval = wv;
        gtp_pkg::A_START_DATE: next_s.start_date = wv;
        gtp_pkg::A_START_TIME: next_s.start_hms = wv[23:0];
        gtp_pkg::A_NOW_DATE: next_s.now_date = wv;
        gtp_pkg::A_NOW_TIME: begin
          next_s.tod = hms_to_sec(wv[23:0]);
          next_s.sub = '0;
        end
        gtp_pkg::A_OFFSET: next_s.offset = wv[15:0];
        gtp_pkg::A_LEAP: next_s.leap = wv[7:0];
        gtp_pkg::A_TIMECODE: next_s.tc_state = gtp_pkg::TC_WAIT;
        gtp_pkg::A_IRQ_MASK: next_s.irq_mask = wv[gtp_pkg::NIRQ-1:0];
        default: begin
        end
      endcase
    end

    // events set after any clear, so a set in the clearing cycle survives
    next_s.irq_stat = next_s.irq_stat | ev;
    next_s.irq = |(next_s.irq_stat & next_s.irq_mask);

    // outputs: inactive level marks the on-time edge when it is left
    next_s.second_mark = (next_s.sub < SUB_HALF) ^ s.ctrl[gtp_pkg::B_SPOL];
    next_s.pulse_out = (next_s.pulse_cnt != 8'h00) ^ s.ctrl[gtp_pkg::B_PPOL];
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s <= '0;
      s.ctrl <= gtp_pkg::RST_CTRL;
      s.interval <= gtp_pkg::RST_INTERVAL;
      s.now_date <= '{gtp_pkg::RST_YEAR, 8'h01, 8'h01};
      s.start_date <= '{gtp_pkg::RST_YEAR, 8'h01, 8'h01};
      s.leap <= gtp_pkg::RST_LEAP;
      s.tc_state <= gtp_pkg::TC_IDLE;
      s.pg_state <= gtp_pkg::PG_IDLE;
    end else begin
      s <= next_s;
    end
  end

  assign wb_dat_o = s.wb_dat;
  assign wb_ack_o = s.wb_ack;
  assign second_mark = s.second_mark;
  assign pulse_out = s.pulse_out;
  assign irq = s.irq;

endmodule

// ---- sim/gtp_time_io_chk.sv ----
`timescale 1ns/1ps
module gtp_time_io_chk #(
  parameter int unsigned CYC_PER_SEC = 20000000
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // timing pins and interrupt
  input wire logic [gtp_pkg::NCH-1:0] tag_channel,
  input wire logic second_mark,
  input wire logic pulse_out,
  input wire logic irq
);
  logic ppol, ok, seen, ctl_wr, ph_wr, act, rd_req, irq_acc;
  logic [3:0] qc;
  logic [7:0] hi;
  logic [31:0] sm;
  // bus decodes seen from outside
  assign ctl_wr = wb_ack_o && wb_we_i && wb_adr_i == gtp_pkg::A_CTRL && wb_sel_i[0];
  assign ph_wr = wb_cyc_i && wb_stb_i && wb_we_i && (wb_adr_i == gtp_pkg::A_CTRL
                 || wb_adr_i == gtp_pkg::A_NOW_TIME);
  assign act = pulse_out ^ ppol;
  assign rd_req = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
  assign irq_acc = wb_ack_o && (wb_adr_i == gtp_pkg::A_IRQ_STAT
                   || wb_adr_i == gtp_pkg::A_IRQ_MASK);
  ////////////////////////////////////////
  // run lengths; a control or time write spoils the run in flight, so it is skipped
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ppol <= 1'b0;
      ok <= 1'b0;
      seen <= 1'b0;
      qc <= 4'h0;
      hi <= 8'h00;
      sm <= 32'h0;
    end else begin
      if (ctl_wr) ppol <= wb_dat_i[gtp_pkg::B_PPOL];
      qc <= ctl_wr ? 4'h0 : (qc == 4'hf ? qc : qc + 4'h1);
      hi <= act ? (hi == 8'hff ? hi : hi + 8'h01) : 8'h00;
      if (ctl_wr) ok <= 1'b0;
      else if (act && hi == 8'h00) ok <= (qc > 4'h4);
      sm <= $changed(second_mark) ? 32'h1 : sm + 32'h1;
      if (ph_wr) seen <= 1'b0;
      else if ($changed(second_mark)) seen <= 1'b1;
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_follows_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered next cycle");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i && !wb_ack_o))
    else $error("ack without request");
  dat_hold_a: assert property (!rd_req |=> $stable(wb_dat_o))
    else $error("read data moved without a read");
  unmapped_zero_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h80 |->
    wb_dat_o == 32'h0) else $error("unmapped read not zero");
  reset_quiet_a: assert property ($past(rst) |-> !wb_ack_o && !irq && !pulse_out)
    else $error("outputs busy after reset");
  irq_clear_a: assert property ($fell(irq) |-> irq_acc || $past(irq_acc))
    else $error("irq fell without status read or mask write");
  pulse_width_a: assert property ($fell(act) && ok |-> hi == gtp_pkg::PULSE_CYC)
    else $error("pulse width wrong");
  mark_half_a: assert property ($changed(second_mark) && seen |-> sm == CYC_PER_SEC / 2)
    else $error("second mark half period wrong");
  cover property ($rose(irq));
  cover property ($fell(act) && ok);
  cover property (wb_ack_o && wb_adr_i == gtp_pkg::A_DATA2);
endmodule
bind gtp_time_io gtp_time_io_chk #(.CYC_PER_SEC(CYC_PER_SEC)) i_gtp_time_io_chk (
  .sys_clk(sys_clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .tag_channel(tag_channel),
  .second_mark(second_mark), .pulse_out(pulse_out), .irq(irq));

// ---- sim/gtp_host.sv ----
`timescale 1ns/1ps
module gtp_host (
  // clock
  input wire logic sys_clk,
  // request out, answer in
  output gtp_pkg::gtp_wb_req_s req,
  input wire logic [31:0] rdat,
  input wire logic ack
);
  initial req = '0;
  // one classic cycle; everything held until ack is sampled, then released
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge sys_clk);
    req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hf, dat: d};
    do @(posedge sys_clk); while (ack !== 1'b1);
    q = rdat;
    req <= '0;
  endtask
endmodule

// ---- sim/gtp_time_io_tb.sv ----
`timescale 1ns/1ps
module gtp_time_io_tb;
  import gtp_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] pins = 3'h0;
  gtp_wb_req_s req;
  logic [31:0] rdat, q;
  logic ack, second_mark, pulse_out, irq, sawirq;
  int err_count = 0;
  int checks = 0;
  int unsigned tick = 0;
  int unsigned t0, d, f, l, cnt;
  always #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk) tick <= tick + 1;
  gtp_time_io #(.CYC_PER_SEC(1000)) i_gtp_time_io (.sys_clk(sys_clk), .rst(rst),
    .wb_cyc_i(req.cyc), .wb_stb_i(req.stb), .wb_we_i(req.we), .wb_adr_i(req.adr),
    .wb_sel_i(req.sel), .wb_dat_i(req.dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .tag_channel(pins), .second_mark(second_mark), .pulse_out(pulse_out), .irq(irq));
  gtp_host i_gtp_host (.sys_clk(sys_clk), .req(req), .rdat(rdat), .ack(ack));
  ////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    i_gtp_host.xfer(1'b1, a, v, q);
  endtask
  task automatic rd(input logic [7:0] a);
    i_gtp_host.xfer(1'b0, a, 32'h0, q);
  endtask
  task automatic rc(input logic [7:0] a, input string nm, input logic [31:0] e);
    rd(a);
    chk(nm, q, e);
  endtask
  task automatic waitc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // count rising edges of the pulse output, first and last, and any irq
  task automatic watch(input int n);
    logic pp;
    pp = pulse_out;
    cnt = 0;
    sawirq = 1'b0;
    repeat (n) begin
      @(posedge sys_clk);
      if (irq === 1'b1) sawirq = 1'b1;
      if (pulse_out === 1'b1 && pp === 1'b0) begin
        if (cnt == 0) f = tick;
        l = tick;
        cnt++;
      end
      pp = pulse_out;
    end
  endtask
  // ten 300-cycle pin pulses, 350 apart, from second 36000
  task automatic tagrun(input logic [2:0] m);
    wr(A_NOW_TIME, 32'h000a_0000);
    waitc(50);
    repeat (10) begin
      pins <= m;
      waitc(300);
      pins <= 3'h0;
      waitc(50);
    end
  endtask
  task automatic drain(input logic [7:0] a, input int s0, input int s7);
    for (int k = 0; k < 8; k++) begin
      rd(a);
      if (k == 0) chk("first stamp", {15'h0, q[31:15]}, 32'(36000 + s0));
      if (k == 7) chk("last stamp", {15'h0, q[31:15]}, 32'(36000 + s7));
    end
    rc(a, "empty read", 32'h0);
  endtask
  task automatic results;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  ////////////////////////////////////////
  // watchdog: the whole sequence needs about 18500 cycles
  initial begin
    waitc(60000);
    err_count++;
    results();
  end
  ////////////////////////////////////////
  initial begin
    waitc(10);
    rst <= 1'b0;
    rc(A_CTRL, "ctrl", {24'h0, RST_CTRL});
    rc(A_INTERVAL, "interval", RST_INTERVAL);
    rc(A_NOW_DATE, "date", 32'h07d0_0101);
    rc(A_IRQ_MASK, "mask", 32'h0);
    rc(8'h80, "unmapped", 32'h0);
    wr(A_LEAP, 32'h12);
    rc(A_LEAP, "leap", 32'h12);
    wr(A_INTERVAL, 32'h3);
    rc(A_INTERVAL, "interval", 32'h3);
    wr(A_START_DATE, 32'h07d0_0101);
    rc(A_START_DATE, "start date", 32'h07d0_0101);
    wr(A_OFFSET, 32'h0);
    wr(A_NOW_TIME, 32'h000a_0000);
    rc(A_NOW_TIME, "local time", 32'd36000);
    wr(A_OFFSET, 32'h011e);
    rc(A_OFFSET, "offset", 32'h011e);
    rc(A_NOW_TIME, "shifted time", 32'd41400);
    wr(A_OFFSET, 32'h0);
    chk("mark rising", {31'h0, second_mark}, 32'h1);
    wr(A_CTRL, 32'h4);
    waitc(3);
    chk("mark falling", {31'h0, second_mark}, 32'h0);
    rc(A_CTRL, "ctrl", 32'h4);
    wr(A_CTRL, 32'h0);
    // timecode: not before the window opens, names the next second
    wr(A_NOW_TIME, 32'h000a_0000);
    t0 = tick;
    wr(A_TIMECODE, 32'h0);
    rd(A_TIMECODE);
    chk("tc early", {31'h0, q[31]}, 32'h0);
    do rd(A_TIMECODE); while (q[31] !== 1'b1 && tick - t0 < 990);
    d = tick - t0;
    chk("tc window", {31'h0, d >= 19 && d <= 35}, 32'h1);
    chk("tc value", q, {1'b1, 14'h0, 17'd36001});
    rc(A_IRQ_STAT, "tc status", 32'h2);
    rc(A_IRQ_STAT, "status cleared", 32'h0);
    waitc(1010 - (tick - t0));
    rd(A_TIMECODE);
    chk("tc expired", {31'h0, q[31]}, 32'h0);
    // single pulse two seconds ahead, interrupt unmasked
    wr(A_IRQ_MASK, 32'h1);
    wr(A_START_TIME, 32'h000a_0002);
    rc(A_START_TIME, "start time", 32'h000a_0002);
    wr(A_NOW_TIME, 32'h000a_0000);
    t0 = tick;
    wr(A_CTRL, 32'h8);
    watch(4500);
    chk("single count", cnt, 32'h1);
    chk("single delay", {31'h0, f - t0 >= 1995 && f - t0 <= 2010}, 32'h1);
    chk("irq up", {31'h0, irq}, 32'h1);
    rc(A_IRQ_STAT, "pulse status", 32'h1);
    waitc(3);
    chk("irq down", {31'h0, irq}, 32'h0);
    // train every two seconds with the interrupt masked
    wr(A_IRQ_MASK, 32'h0);
    wr(A_INTERVAL, 32'h2);
    wr(A_CTRL, 32'h0);
    wr(A_START_TIME, 32'h000a_0001);
    wr(A_NOW_TIME, 32'h000a_0000);
    wr(A_CTRL, 32'h9);
    watch(5500);
    chk("train count", cnt, 32'h3);
    chk("train span", l - f, 32'd4000);
    chk("masked irq", {31'h0, sawirq}, 32'h0);
    rd(A_IRQ_STAT);
    chk("masked status", {31'h0, q[0]}, 32'h1);
    wr(A_CTRL, 32'h0);
    wr(A_CTRL, 32'h2);
    waitc(3);
    chk("pulse idle inverted", {31'h0, pulse_out}, 32'h1);
    rc(A_CTRL, "ctrl", 32'h2);
    wr(A_CTRL, 32'h0);
    // keep first on channels 1 and 3, then clear channel 3 alone
    wr(A_TAG_CLEAR, 32'h0);
    tagrun(3'b101);
    rc(A_POINTS, "points", 32'h808);
    rc(A_OVF_CHAN, "ovf chan", 32'h020002);
    rc(A_OVF_TOTAL, "ovf total", 32'h4);
    rc(A_IRQ_STAT, "tag status", 32'h34);
    wr(A_TAG_CLEAR, 32'h4);
    rc(A_POINTS, "points", 32'h008);
    drain(A_DATA1, 0, 2);
    wr(A_TAG_CLEAR, 32'h0);
    rc(A_OVF_TOTAL, "ovf total", 32'h0);
    // keep last, channel 2 on falling edges
    wr(A_CTRL, 32'ha0);
    rc(A_CTRL, "ctrl", 32'ha0);
    tagrun(3'b111);
    drain(A_DATA2, 1, 3);
    drain(A_DATA1, 0, 3);
    results();
  end
endmodule
